// ==== hdl/adcc_map.svh ====
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFF_CTRL     3'h0
`define ADCC_OFF_CLKSEL   3'h1
`define ADCC_OFF_RES_LO   3'h2
`define ADCC_OFF_RES_HI   3'h3
`define ADCC_OFF_IRQ      3'h4
`define ADCC_CTRL_DONE    0
`define ADCC_CTRL_CH_LO   2
`define ADCC_CTRL_CH_HI   4
`define ADCC_CTRL_PIN_LO  5
`define ADCC_CTRL_PIN_HI  7
`define ADCC_CTRL_START   1
`define ADCC_IRQ_GLOBAL   0
`define ADCC_IRQ_CONV_EN  1
`define ADCC_IRQ_FLAG     2
`define ADCC_CTRL_RESET   8'h03
`define ADCC_CLKSEL_RESET 8'h00
`define ADCC_DIV2_LAST    5'h01
`define ADCC_DIV8_LAST    5'h07
`define ADCC_DIV32_LAST   5'h1f
`define ADCC_CONV_TICKS   4'hd
`endif

// ==== hdl/adcc_pkg.sv ====
// Types shared by the converter control files.
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_DIV2  = 2'b00,
    ADCC_DIV8  = 2'b01,
    ADCC_DIV32 = 2'b10,
    ADCC_DIVX  = 2'b11
  } adcc_div_type;
  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_HELD  = 2'b01,
    ADCC_CONV  = 2'b10
  } adcc_state_type;
endpackage : adcc_pkg

// ==== hdl/adcc_clkdiv.sv ====
// Conversion clock divider producing a one-cycle enable pulse.
`include "adcc_map.svh"
module adcc_clkdiv
  import adcc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         clear,
  input  wire adcc_div_type div_sel,
  output logic              tick
);
  logic [4:0] count;
  logic [4:0] last;

  always_comb begin
    unique case (div_sel)
      ADCC_DIV2:  last = `ADCC_DIV2_LAST;
      ADCC_DIV8:  last = `ADCC_DIV8_LAST;
      ADCC_DIV32: last = `ADCC_DIV32_LAST;
      ADCC_DIVX:  last = `ADCC_DIV32_LAST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset || clear) begin
      count <= 5'h00;
    end else if (count >= last) begin
      count <= 5'h00;
    end else begin
      count <= count + 5'h01;
    end
  end

  assign tick = !reset && !clear && (count >= last);
endmodule : adcc_clkdiv

// ==== hdl/adcc_top.sv ====
// Converter control: registers, start sequencing, done flag, divider and pin overrides.
// Functional notes
// - Pin config zero: ports plain, converter off.
// - Start rising then falling begins conversion.
// - Start held high resets, done flag one.
// - Hardware clears done flag after conversion.
// - Conversion end sets request, maybe interrupts.
// - Divider codes give divide 2, 8, 32.
// - Result high holds 11..4, low 3..0.
// - Pin config selects I/O or analog.
// - Analog pins drop their pull-high.
// - Analog pins override port direction.
// - Restart pulse leaves done flag high.
// - Results valid once done flag low.
// - Conversion runs without stalling the processor.
// - Converter yields 12-bit value.
`include "adcc_map.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int PINS      = 8,
  parameter int RES_WIDTH = 12
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [7:0]           reg_rdata,
  input  wire logic [PINS-1:0]      shared_port_direction_reg,
  input  wire logic [PINS-1:0]      pull_high_option,
  input  wire logic [RES_WIDTH-1:0] analog_sample,
  output logic                      converter_power_on,
  output logic                      converter_clock_tick,
  output logic                      converter_reset,
  output logic      [2:0]           sample_channel,
  output logic      [PINS-1:0]      analog_pin_enable,
  output logic      [PINS-1:0]      pin_direction_eff,
  output logic      [PINS-1:0]      pin_pull_high_eff,
  output logic                      converter_irq
);
  logic [7:0]           converter_control_reg;
  logic [7:0]           converter_clock_select_reg;
  logic [1:0]           irq_control_reg;
  logic                 irq_flag;
  logic [RES_WIDTH-1:0] result;
  logic [3:0]           tick_count;
  logic                 tick;
  logic                 conv_end;
  adcc_state_type       state;

  logic [2:0] analog_pin_config;
  logic [2:0] analog_channel_select;
  logic       start_bit;
  logic       conversion_done_n;
  logic       wr_ctrl;
  logic       wr_irq;

  // Pin config, channel, start and done each own separate bits, so a start pulse never moves pins.
  assign analog_pin_config     = converter_control_reg[`ADCC_CTRL_PIN_HI:`ADCC_CTRL_PIN_LO];
  assign analog_channel_select = converter_control_reg[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
  assign start_bit             = converter_control_reg[`ADCC_CTRL_START];
  assign conversion_done_n     = converter_control_reg[`ADCC_CTRL_DONE];
  assign wr_ctrl               = reg_write && (reg_addr == `ADCC_OFF_CTRL);
  assign wr_irq                = reg_write && (reg_addr == `ADCC_OFF_IRQ);

  // The channel msb is kept as written; software is expected to keep it zero.
  assign sample_channel = analog_channel_select;

  // Pin config n enables the lowest n pins as analog inputs; zero keeps all pins digital.
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign analog_pin_enable[gi] = (analog_pin_config > 3'(gi));
      assign pin_direction_eff[gi] = analog_pin_enable[gi] | shared_port_direction_reg[gi];
      assign pin_pull_high_eff[gi] = pull_high_option[gi] & ~analog_pin_enable[gi];
    end
  endgenerate

  assign converter_power_on = (analog_pin_config != 3'h0);

  adcc_clkdiv u_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clear   (state != ADCC_CONV),
    .div_sel (adcc_div_type'(converter_clock_select_reg[1:0])),
    .tick    (tick)
  );

  assign converter_clock_tick = tick;
  assign converter_reset      = (state == ADCC_HELD) || !converter_power_on;
  assign conv_end = (state == ADCC_CONV) && tick && (tick_count == `ADCC_CONV_TICKS);

  // Sequencer runs by itself; the bus never waits on it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ADCC_IDLE;
    end else if (start_bit) begin
      state <= ADCC_HELD;
    end else begin
      unique case (state)
        ADCC_IDLE: state <= ADCC_IDLE;
        ADCC_HELD: state <= converter_power_on ? ADCC_CONV : ADCC_IDLE;
        ADCC_CONV: state <= conv_end ? ADCC_IDLE : ADCC_CONV;
        default:   state <= ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state != ADCC_CONV) begin
      tick_count <= 4'h0;
    end else if (tick) begin
      tick_count <= tick_count + 4'h1;
    end
  end

  // The result is captured on the last tick, on the same clock edge as the done flag falls.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      result <= '0;
    end else if (conv_end) begin
      result <= analog_sample;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      converter_control_reg <= `ADCC_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        converter_control_reg[7:1] <= reg_wdata[7:1];
      end
      if (start_bit || (wr_ctrl && reg_wdata[`ADCC_CTRL_START])) begin
        converter_control_reg[`ADCC_CTRL_DONE] <= 1'b1;
      end else if (conv_end) begin
        converter_control_reg[`ADCC_CTRL_DONE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      converter_clock_select_reg <= `ADCC_CLKSEL_RESET;
    end else if (reg_write && reg_addr == `ADCC_OFF_CLKSEL) begin
      converter_clock_select_reg <= {6'h00, reg_wdata[1:0]};
    end
  end

  // A conversion end in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_control_reg <= 2'b00;
      irq_flag        <= 1'b0;
    end else begin
      if (wr_irq) begin
        irq_control_reg <= {reg_wdata[`ADCC_IRQ_CONV_EN], reg_wdata[`ADCC_IRQ_GLOBAL]};
      end
      if (conv_end) begin
        irq_flag <= 1'b1;
      end else if (wr_irq && !reg_wdata[`ADCC_IRQ_FLAG]) begin
        irq_flag <= 1'b0;
      end
    end
  end

  assign converter_irq = irq_flag && irq_control_reg[0] && irq_control_reg[1];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `ADCC_OFF_CTRL:   reg_rdata <= converter_control_reg;
        `ADCC_OFF_CLKSEL: reg_rdata <= converter_clock_select_reg;
        `ADCC_OFF_RES_LO: reg_rdata <= {result[3:0], 4'h0};
        `ADCC_OFF_RES_HI: reg_rdata <= result[11:4];
        `ADCC_OFF_IRQ:    reg_rdata <= {5'h00, irq_flag, irq_control_reg};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Keep the done-flag value visible; it is read through the control register.
  logic unused_done;
  assign unused_done = conversion_done_n;
endmodule : adcc_top

// ==== verif/adcc_top_sva.sv ====
// Checker of the converter control port relations.
module adcc_top_sva #(
  parameter int PINS      = 8,
  parameter int RES_WIDTH = 12
)
(
  input wire logic            sys_clk,
  input wire logic            reset,
  input wire logic [2:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_write,
  input wire logic            reg_read,
  input wire logic [7:0]      reg_rdata,
  input wire logic [PINS-1:0] shared_port_direction_reg,
  input wire logic [PINS-1:0] pull_high_option,
  input wire logic            converter_power_on,
  input wire logic            converter_clock_tick,
  input wire logic            converter_reset,
  input wire logic [PINS-1:0] analog_pin_enable,
  input wire logic [PINS-1:0] pin_direction_eff,
  input wire logic [PINS-1:0] pin_pull_high_eff,
  input wire logic            converter_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_power_off_pins: assert property ((analog_pin_enable == '0) == !converter_power_on)
    else $error("power and pin enables disagree");
  a_pins_low_first: assert property ((analog_pin_enable & (analog_pin_enable + 1'b1)) == '0)
    else $error("analog pins not a low group");
  a_pull_drop: assert property (pin_pull_high_eff == (pull_high_option & ~analog_pin_enable))
    else $error("pull-high kept on analog pin");
  a_dir_override: assert property (pin_direction_eff ==
    (shared_port_direction_reg | analog_pin_enable))
    else $error("direction not overridden");
  a_tick_held: assert property (converter_reset |-> !converter_clock_tick)
    else $error("tick while converter held");
  a_tick_spacing: assert property (converter_clock_tick |=> !converter_clock_tick)
    else $error("ticks back to back");
  a_start_holds: assert property (reg_write && reg_addr == 3'h0 && reg_wdata[1]
    |-> ##[1:2] converter_reset)
    else $error("start high did not hold converter");
  a_start_runs: assert property (reg_write && reg_addr == 3'h0 && !reg_wdata[1] && (reg_wdata[7:5] != 3'h0)
    |-> ##[1:2] !converter_reset)
    else $error("start low did not release converter");
  a_low_nibble: assert property (reg_read && reg_addr == 3'h2 |=> reg_rdata[3:0] == 4'h0)
    else $error("result low nibble not zero");
  // Each conversion must show its divided clock soon after release.
  a_conv_ticks: assert property ($fell(converter_reset) |-> ##[1:40] converter_clock_tick)
    else $error("no conversion tick after release");
  c_irq: cover property ($rose(converter_irq));
  c_off: cover property (!converter_power_on);
  c_tick: cover property (converter_clock_tick);
endmodule : adcc_top_sva
bind adcc_top adcc_top_sva #(.PINS(PINS), .RES_WIDTH(RES_WIDTH)) adcc_top_sva_i (.*);

// ==== verif/adcc_top_tb_top.sv ====
// Self-checking bench of the converter control.
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset, reg_write, reg_read, pw, tk, rs, irq;
  logic [2:0]  reg_addr, ch;
  logic [7:0]  reg_wdata, rdata, dir, pull, ape, pde, ppe, d;
  logic [11:0] sample;
  int          errors, total_checks, n, g;
  adcc_top adcc_top_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .shared_port_direction_reg(dir), .pull_high_option(pull), .analog_sample(sample),
    .converter_power_on(pw), .converter_clock_tick(tk), .converter_reset(rs),
    .sample_channel(ch), .analog_pin_enable(ape), .pin_direction_eff(pde),
    .pin_pull_high_eff(ppe), .converter_irq(irq));
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK("rdata", e, d)
  endtask : rchk
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #50us;
    errors++;
    finish_test;
  end
  initial begin
    reset = 1; reg_addr = 0; reg_wdata = 0; reg_write = 0; reg_read = 0;
    dir = 8'h40; pull = 8'hff; sample = 12'habc;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(3'h0, 8'h03);
    rchk(3'h1, 8'h00);
    rchk(3'h4, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(3'h1, 8'(i));
      wr(3'h4, (i == 1) ? 8'h01 : 8'h03);
      wr(3'h0, 8'ha6);
      step; step;
      `CHK("held", 1'b1, rs)
      rd(3'h0, d);
      `CHK("done_n", 1'b1, d[0])
      wr(3'h0, 8'ha4);
      n = 0;
      while (tk !== 1'b1 && n < 100) begin step; n++; end
      g = 0;
      do begin step; g++; end while (tk !== 1'b1 && g < 64);
      `CHK("gap", 2 << (2 * i), g)
      n = 0;
      do begin rd(3'h0, d); n++; end while (d[0] !== 1'b0 && n < 400);
      `CHK("done_n", 1'b0, d[0])
      `CHK("irq", (i != 1), irq)
      rchk(3'h4, (i == 1) ? 8'h05 : 8'h07);
      rchk(3'h3, 8'hab);
      rchk(3'h2, 8'hc0);
      `CHK("chan", 3'h1, ch)
      `CHK("pins", 8'h1f, ape)
      `CHK("dir", 8'h5f, pde)
      `CHK("pull", 8'he0, ppe)
    end
    wr(3'h4, 8'h03);
    step;
    `CHK("irq", 1'b0, irq)
    wr(3'h0, 8'h00);
    step;
    `CHK("power", 1'b0, pw)
    `CHK("pins", 8'h00, ape)
    `CHK("pull", 8'hff, ppe)
    rchk(3'h5, 8'h00);
    finish_test;
  end
endmodule : adcc_top_tb_top
